// file: hw/pru_axil_slave.sv
`default_nettype none
module pru_axil_slave
	import pru_pkg::*;
(
	input  wire logic                  clk,
	input  wire logic                  srst,
	input  wire logic [PRU_ADDR_W-1:0] awaddr,
	input  wire logic                  awvalid,
	output var  logic                  awready,
	input  wire logic [PRU_DATA_W-1:0] wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output var  logic                  wready,
	output var  logic [1:0]            bresp,
	output var  logic                  bvalid,
	input  wire logic                  bready,
	input  wire logic [PRU_ADDR_W-1:0] araddr,
	input  wire logic                  arvalid,
	output var  logic                  arready,
	output var  logic [PRU_DATA_W-1:0] rdata,
	output var  logic [1:0]            rresp,
	output var  logic                  rvalid,
	input  wire logic                  rready,
	output var  pru_wcmd_s             wcmd,
	input  wire logic                  wr_hit,
	output var  pru_idx_t              rd_idx,
	input  wire logic [PRU_REG_W-1:0]  rd_data,
	input  wire logic                  rd_hit
);

	logic                  aw_held_r;
	logic                  w_held_r;
	logic [PRU_ADDR_W-1:0] awaddr_r;
	logic [PRU_DATA_W-1:0] wdata_r;
	logic [3:0]            wstrb_r;

	wire logic aw_take = awvalid & awready;
	wire logic w_take = wvalid & wready;
	wire logic aw_have = aw_held_r | aw_take;
	wire logic w_have = w_held_r | w_take;
	// Address and data may arrive in either order; commit once both are here
	wire logic do_write = aw_have & w_have & ~bvalid;
	wire logic aw_held_nxt = aw_have & ~do_write;
	wire logic w_held_nxt = w_have & ~do_write;
	wire logic bvalid_nxt = do_write | (bvalid & ~bready);
	wire logic ar_take = arvalid & arready;
	wire logic rvalid_nxt = ar_take | (rvalid & ~rready);

	wire logic [PRU_ADDR_W-1:0] wa = aw_held_r ? awaddr_r : awaddr;
	wire logic [PRU_DATA_W-1:0] wd = w_held_r ? wdata_r : wdata;
	wire logic [3:0]            ws = w_held_r ? wstrb_r : wstrb;

	// Registers live in byte lane 0 only
	assign wcmd.en = do_write & ws[0];
	assign wcmd.idx = wa[PRU_ADDR_W-1:PRU_IDX_LSB];
	assign wcmd.data = wd[PRU_REG_W-1:0];
	assign rd_idx = araddr[PRU_ADDR_W-1:PRU_IDX_LSB];

	always_ff @(posedge clk) begin
		if (srst) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awready <= 1'b0;
			wready <= 1'b0;
			bvalid <= 1'b0;
			bresp <= PRU_RESP_OKAY;
			arready <= 1'b0;
			rvalid <= 1'b0;
			rresp <= PRU_RESP_OKAY;
			rdata <= '0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else begin
			aw_held_r <= aw_held_nxt;
			w_held_r <= w_held_nxt;
			awready <= ~aw_held_nxt;
			wready <= ~w_held_nxt;
			bvalid <= bvalid_nxt;
			arready <= ~rvalid_nxt;
			rvalid <= rvalid_nxt;
			if (aw_take) begin
				awaddr_r <= awaddr;
			end
			if (w_take) begin
				wdata_r <= wdata;
				wstrb_r <= wstrb;
			end
			if (do_write) begin
				bresp <= wr_hit ? PRU_RESP_OKAY : PRU_RESP_SLVERR;
			end
			if (ar_take) begin
				rdata <= {{(PRU_DATA_W-PRU_REG_W){1'b0}}, rd_data};
				rresp <= rd_hit ? PRU_RESP_OKAY : PRU_RESP_SLVERR;
			end
		end
	end

endmodule
`default_nettype wire

// file: hw/pru_pin_route_unit.sv
// Functional notes
// - Each control bit enables a pin function or picks default versus alternative pin.
// - Control A bit 5 moves lookup table one output to its alternative pin.
// - Control A bit 4 moves lookup table zero output to its alternative pin.
// - Event output two drives its pin only while control A bit 2 is set.
// - Event output one drives its pin only while control A bit 1 is set.
// - Event output zero drives its pin only while control A bit 0 is set.
// - Control B bit 2 moves all synchronous serial signals to alternative pins.
// - Control B bit 0 moves all asynchronous serial signals to alternative pins.
// - Control C bits 5..3 move waveforms 5..3, only in split timer mode.
// - In normal timer mode control C bits 5..3 do not affect routing.
// - Control C bits 2..0 move waveforms 2..0 in every timer mode.
// - In split mode bits 2..0 route the low-byte compare channels 2..0.
// - Control D bit 0 moves the second timer output to its alternative pin.
//
// The AXI4-Lite slave port was decided locally.
`default_nettype none
module pru_pin_route_unit
	import pru_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    srst,
	input  wire logic [PRU_ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output var  logic                    s_axi_awready,
	input  wire logic [PRU_DATA_W-1:0]   s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output var  logic                    s_axi_wready,
	output var  logic [1:0]              s_axi_bresp,
	output var  logic                    s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [PRU_ADDR_W-1:0]   s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output var  logic                    s_axi_arready,
	output var  logic [PRU_DATA_W-1:0]   s_axi_rdata,
	output var  logic [1:0]              s_axi_rresp,
	output var  logic                    s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	input  wire logic                    main_pwm_timer_split,
	input  wire pru_drive_s [PRU_LINES-1:0]  periph_drive,
	output var  logic [PRU_LINES-1:0]        periph_in,
	output var  pru_drive_s [PRU_LINES-1:0]  def_pad,
	output var  pru_drive_s [PRU_LINES-1:0]  alt_pad,
	input  wire logic [PRU_LINES-1:0]        def_pad_in,
	input  wire logic [PRU_LINES-1:0]        alt_pad_in,
	input  wire logic [PRU_EVENTS-1:0]       event_value,
	output var  pru_drive_s [PRU_EVENTS-1:0] event_pad
);

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	logic [PRU_REG_W-1:0] pin_route_ctrl_lut_event_r;
	logic [PRU_REG_W-1:0] pin_route_ctrl_serial_r;
	logic [PRU_REG_W-1:0] pin_route_ctrl_waveform_r;
	logic [PRU_REG_W-1:0] pin_route_ctrl_timer_b_r;
	logic [PRU_REG_W-1:0] rd_data;
	logic                 rd_hit;

	pru_wcmd_s wcmd;
	pru_idx_t  rd_idx;

	wire logic wr_hit = wcmd.idx <= PRU_IDX_LAST;
	wire logic wr_a = wcmd.en & (wcmd.idx == PRU_IDX_LUT_EVENT);
	wire logic wr_b = wcmd.en & (wcmd.idx == PRU_IDX_SERIAL);
	wire logic wr_c = wcmd.en & (wcmd.idx == PRU_IDX_WAVEFORM);
	wire logic wr_d = wcmd.en & (wcmd.idx == PRU_IDX_TIMER_B);

	pru_axil_slave u_bus (
		.clk     (clk),
		.srst    (srst),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wcmd    (wcmd),
		.wr_hit  (wr_hit),
		.rd_idx  (rd_idx),
		.rd_data (rd_data),
		.rd_hit  (rd_hit)
	);

	// Masking at the write keeps unimplemented bits at zero for good
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_route_ctrl_lut_event_r <= PRU_CTRL_RST;
			pin_route_ctrl_serial_r <= PRU_CTRL_RST;
			pin_route_ctrl_waveform_r <= PRU_CTRL_RST;
			pin_route_ctrl_timer_b_r <= PRU_CTRL_RST;
		end else begin
			if (wr_a) begin
				pin_route_ctrl_lut_event_r <= wcmd.data & PRU_MASK_LUT_EVENT;
			end
			if (wr_b) begin
				pin_route_ctrl_serial_r <= wcmd.data & PRU_MASK_SERIAL;
			end
			if (wr_c) begin
				pin_route_ctrl_waveform_r <= wcmd.data & PRU_MASK_WAVEFORM;
			end
			if (wr_d) begin
				pin_route_ctrl_timer_b_r <= wcmd.data & PRU_MASK_TIMER_B;
			end
		end
	end

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		rd_hit = 1'b1;
		if (rd_idx == PRU_IDX_LUT_EVENT) begin
			rd_data = pin_route_ctrl_lut_event_r;
		end else if (rd_idx == PRU_IDX_SERIAL) begin
			rd_data = pin_route_ctrl_serial_r;
		end else if (rd_idx == PRU_IDX_WAVEFORM) begin
			rd_data = pin_route_ctrl_waveform_r;
		end else if (rd_idx == PRU_IDX_TIMER_B) begin
			rd_data = pin_route_ctrl_timer_b_r;
		end else begin
			rd_data = PRU_CTRL_RST;
			rd_hit = 1'b0;
		end
	end

	// ----------------------------------------
	// Alternative pin selects
	// ----------------------------------------
	wire logic [PRU_LINES-1:0] alt_sel;

	assign alt_sel[PRU_LN_LKUP_ONE] = pin_route_ctrl_lut_event_r[PRU_BIT_LKUP_ONE];
	assign alt_sel[PRU_LN_LKUP_ZERO] = pin_route_ctrl_lut_event_r[PRU_BIT_LKUP_ZERO];
	assign alt_sel[PRU_LN_TCB] = pin_route_ctrl_timer_b_r[PRU_BIT_TCB];

	genvar g;
	generate
		for (g = 0; g < PRU_SPI_N; g++) begin : g_spi
			assign alt_sel[PRU_LN_SPI_FIRST+g] = pin_route_ctrl_serial_r[PRU_BIT_SPI];
		end
		for (g = 0; g < PRU_USART_N; g++) begin : g_usart
			assign alt_sel[PRU_LN_USART_FIRST+g] = pin_route_ctrl_serial_r[PRU_BIT_USART];
		end
		// Upper waveform bits are gated by split mode so a normal-mode timer
		// is never split across pins by a stale setting
		for (g = 0; g < PRU_WAVE_N; g++) begin : g_wave
			if (g >= PRU_WAVE_SPLIT_FIRST) begin : g_hi
				assign alt_sel[PRU_LN_WAVE0+g] =
					pin_route_ctrl_waveform_r[PRU_BIT_WAVE0+g] & main_pwm_timer_split;
			end else begin : g_lo
				assign alt_sel[PRU_LN_WAVE0+g] =
					pin_route_ctrl_waveform_r[PRU_BIT_WAVE0+g];
			end
		end
	endgenerate

	// ----------------------------------------
	// Pad routing
	// ----------------------------------------
	generate
		for (g = 0; g < PRU_LINES; g++) begin : g_line
			pru_route_cell u_cell (
				.clk       (clk),
				.srst      (srst),
				.alt_sel   (alt_sel[g]),
				.drive     (periph_drive[g]),
				.def_in    (def_pad_in[g]),
				.alt_in    (alt_pad_in[g]),
				.def_pad_r (def_pad[g]),
				.alt_pad_r (alt_pad[g]),
				.line_in_r (periph_in[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Event outputs
	// ----------------------------------------
	// Disabled event pins stay released so the pad serves general I/O
	wire logic [PRU_EVENTS-1:0] ev_en =
		pin_route_ctrl_lut_event_r[PRU_BIT_EV0+PRU_EVENTS-1:PRU_BIT_EV0];

	generate
		for (g = 0; g < PRU_EVENTS; g++) begin : g_ev
			always_ff @(posedge clk) begin
				if (srst) begin
					event_pad[g] <= '{o: 1'b0, oe: 1'b0};
				end else begin
					event_pad[g].o <= event_value[g] & ev_en[g];
					event_pad[g].oe <= ev_en[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	sequence s_write_a;
		wr_a ##1 1'b1;
	endsequence

	a_write_a_lands: assert property (
		s_write_a |-> pin_route_ctrl_lut_event_r == ($past(wcmd.data) & PRU_MASK_LUT_EVENT))
		else $error("control A write not stored");

	a_lookup_one_alt: assert property (
		pin_route_ctrl_lut_event_r[PRU_BIT_LKUP_ONE] |=>
		alt_pad[PRU_LN_LKUP_ONE] == $past(periph_drive[PRU_LN_LKUP_ONE]) &&
		!def_pad[PRU_LN_LKUP_ONE].oe)
		else $error("lookup one not on alternative pin");

	a_lookup_zero_def: assert property (
		!pin_route_ctrl_lut_event_r[PRU_BIT_LKUP_ZERO] |=>
		def_pad[PRU_LN_LKUP_ZERO] == $past(periph_drive[PRU_LN_LKUP_ZERO]) &&
		!alt_pad[PRU_LN_LKUP_ZERO].oe)
		else $error("lookup zero not on default pin");

	generate
		for (g = 0; g < PRU_EVENTS; g++) begin : g_ev_chk
			a_event_pin_gate: assert property (
				ev_en[g] == $past(ev_en[g]) |->
				event_pad[g].oe == ev_en[g] && (!event_pad[g].oe || event_pad[g].o == $past(event_value[g])))
				else $error("event pin enable mismatch");
		end
	endgenerate

	a_sync_serial_alt: assert property (
		pin_route_ctrl_serial_r[PRU_BIT_SPI] |=>
		def_pad[PRU_LN_SPI_FIRST+PRU_SPI_N-1:PRU_LN_SPI_FIRST] == '0 &&
		periph_in[PRU_LN_SPI_FIRST] == $past(alt_pad_in[PRU_LN_SPI_FIRST]))
		else $error("sync serial not moved");

	a_async_serial_alt: assert property (
		pin_route_ctrl_serial_r[PRU_BIT_USART] |=>
		def_pad[PRU_LN_USART_FIRST+PRU_USART_N-1:PRU_LN_USART_FIRST] == '0)
		else $error("async serial not moved");

	a_wave_split_alt: assert property (
		main_pwm_timer_split && pin_route_ctrl_waveform_r[PRU_WAVE_SPLIT_FIRST] |=>
		alt_pad[PRU_LN_WAVE0+PRU_WAVE_SPLIT_FIRST] ==
		$past(periph_drive[PRU_LN_WAVE0+PRU_WAVE_SPLIT_FIRST]))
		else $error("split waveform not moved");

	a_wave_normal_ignore: assert property (
		!main_pwm_timer_split |=>
		alt_pad[PRU_LN_WAVE0+PRU_WAVE_N-1:PRU_LN_WAVE0+PRU_WAVE_SPLIT_FIRST] == '0)
		else $error("normal mode waveform moved");

	a_wave_low_alt: assert property (
		pin_route_ctrl_waveform_r[PRU_BIT_WAVE0] |=>
		alt_pad[PRU_LN_WAVE0] == $past(periph_drive[PRU_LN_WAVE0]) && !def_pad[PRU_LN_WAVE0].oe)
		else $error("low waveform not moved");

	a_timer_b_alt: assert property (
		pin_route_ctrl_timer_b_r[PRU_BIT_TCB] |=>
		alt_pad[PRU_LN_TCB] == $past(periph_drive[PRU_LN_TCB]))
		else $error("second timer not moved");

	a_reset_clears: assert property (disable iff (1'b0)
		srst |=> pin_route_ctrl_lut_event_r == PRU_CTRL_RST &&
		pin_route_ctrl_waveform_r == PRU_CTRL_RST && event_pad == '0 && alt_pad == '0)
		else $error("reset did not clear");

	a_unused_bits_zero: assert property (
		(pin_route_ctrl_lut_event_r & ~PRU_MASK_LUT_EVENT) == '0 &&
		(pin_route_ctrl_serial_r & ~PRU_MASK_SERIAL) == '0 &&
		(pin_route_ctrl_waveform_r & ~PRU_MASK_WAVEFORM) == '0 &&
		(pin_route_ctrl_timer_b_r & ~PRU_MASK_TIMER_B) == '0)
		else $error("unimplemented bit set");

	// ----------------------------------------
	// Per-line and bus checks
	// ----------------------------------------
	// One pad per line at a time, so two pads never fight over a signal
	generate
		for (g = 0; g < PRU_LINES; g++) begin : g_line_chk
			a_line_alt_pad: assert property (
				alt_sel[g] |=> alt_pad[g] == $past(periph_drive[g]) && def_pad[g] == '0 &&
				periph_in[g] == $past(alt_pad_in[g]))
				else $error("line not on alternative pad");
			a_line_def_pad: assert property (
				!alt_sel[g] |=> def_pad[g] == $past(periph_drive[g]) && alt_pad[g] == '0 &&
				periph_in[g] == $past(def_pad_in[g]))
				else $error("line not on default pad");
		end
	endgenerate

	sequence s_lookup_one_set;
		wr_a && wcmd.data[PRU_BIT_LKUP_ONE] ##1 1'b1;
	endsequence

	a_lookup_one_moves: assert property (
		s_lookup_one_set |=> def_pad[PRU_LN_LKUP_ONE] == '0)
		else $error("lookup one default pad still driven");

	sequence s_timer_b_set;
		wr_d && wcmd.data[PRU_BIT_TCB] ##1 1'b1;
	endsequence

	a_timer_b_moves: assert property (
		s_timer_b_set |=> def_pad[PRU_LN_TCB] == '0)
		else $error("second timer default pad still driven");

	sequence s_resp_waiting;
		s_axi_bvalid && !s_axi_bready;
	endsequence

	sequence s_data_waiting;
		s_axi_rvalid && !s_axi_rready;
	endsequence

	a_bresp_holds: assert property (
		s_resp_waiting |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");

	a_rdata_holds: assert property (
		s_data_waiting |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");

	a_write_miss_err: assert property (
		wcmd.en && !wr_hit |=> s_axi_bvalid && s_axi_bresp == PRU_RESP_SLVERR)
		else $error("unmapped write not refused");

	a_read_miss_err: assert property (
		s_axi_arvalid && s_axi_arready && !rd_hit |=>
		s_axi_rresp == PRU_RESP_SLVERR && s_axi_rdata == '0)
		else $error("unmapped read not refused");

	a_rdata_upper_zero: assert property (
		s_axi_rvalid |-> s_axi_rdata[PRU_DATA_W-1:PRU_REG_W] == '0)
		else $error("read data upper bits set");

endmodule
`default_nettype wire

// file: hw/pru_pkg.sv
`default_nettype none
package pru_pkg;

	// ----------------------------------------
	// Bus and register geometry
	// ----------------------------------------
	localparam int PRU_DATA_W = 32;
	localparam int PRU_ADDR_W = 6;
	localparam int PRU_IDX_LSB = 2;
	localparam int PRU_REG_W = 8;

	typedef logic [PRU_ADDR_W-PRU_IDX_LSB-1:0] pru_idx_t;

	// Register indices; byte address is four times the index
	localparam pru_idx_t PRU_IDX_LUT_EVENT = 4'h0;
	localparam pru_idx_t PRU_IDX_SERIAL    = 4'h1;
	localparam pru_idx_t PRU_IDX_WAVEFORM  = 4'h2;
	localparam pru_idx_t PRU_IDX_TIMER_B   = 4'h3;
	localparam pru_idx_t PRU_IDX_LAST      = 4'h3;

	// Implemented bits per register
	localparam logic [PRU_REG_W-1:0] PRU_MASK_LUT_EVENT = 8'h37;
	localparam logic [PRU_REG_W-1:0] PRU_MASK_SERIAL    = 8'h05;
	localparam logic [PRU_REG_W-1:0] PRU_MASK_WAVEFORM  = 8'h3f;
	localparam logic [PRU_REG_W-1:0] PRU_MASK_TIMER_B   = 8'h01;
	localparam logic [PRU_REG_W-1:0] PRU_CTRL_RST       = 8'h00;

	// Field positions
	localparam int PRU_BIT_LKUP_ONE = 5;
	localparam int PRU_BIT_LKUP_ZERO = 4;
	localparam int PRU_BIT_EV0 = 0;
	localparam int PRU_BIT_SPI = 2;
	localparam int PRU_BIT_USART = 0;
	localparam int PRU_BIT_WAVE0 = 0;
	localparam int PRU_WAVE_SPLIT_FIRST = 3;
	localparam int PRU_BIT_TCB = 0;

	// Routed line numbering
	localparam int PRU_LN_LKUP_ZERO = 0;
	localparam int PRU_LN_LKUP_ONE = 1;
	localparam int PRU_LN_SPI_FIRST = 2;
	localparam int PRU_SPI_N = 4;
	localparam int PRU_LN_USART_FIRST = 6;
	localparam int PRU_USART_N = 4;
	localparam int PRU_LN_WAVE0 = 10;
	localparam int PRU_WAVE_N = 6;
	localparam int PRU_LN_TCB = 16;
	localparam int PRU_LINES = 17;
	localparam int PRU_EVENTS = 3;

	localparam logic [1:0] PRU_RESP_OKAY   = 2'h0;
	localparam logic [1:0] PRU_RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic o;
		logic oe;
	} pru_drive_s;

	typedef struct packed {
		logic                 en;
		pru_idx_t             idx;
		logic [PRU_REG_W-1:0] data;
	} pru_wcmd_s;

endpackage
`default_nettype wire

// file: hw/pru_route_cell.sv
`default_nettype none
module pru_route_cell
	import pru_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic       alt_sel,
	input  wire pru_drive_s drive,
	input  wire logic       def_in,
	input  wire logic       alt_in,
	output var  pru_drive_s def_pad_r,
	output var  pru_drive_s alt_pad_r,
	output var  logic       line_in_r
);

	// The unused pad is released, never left driving a stale level
	wire pru_drive_s idle = '{o: 1'b0, oe: 1'b0};
	wire pru_drive_s def_nxt = alt_sel ? idle : drive;
	wire pru_drive_s alt_nxt = alt_sel ? drive : idle;
	wire logic       in_nxt = alt_sel ? alt_in : def_in;

	always_ff @(posedge clk) begin
		if (srst) begin
			def_pad_r <= idle;
			alt_pad_r <= idle;
			line_in_r <= 1'b0;
		end else begin
			def_pad_r <= def_nxt;
			alt_pad_r <= alt_nxt;
			line_in_r <= in_nxt;
		end
	end

endmodule
`default_nettype wire

// file: testbench/pru_pad_model.sv
`default_nettype none
module pru_pad_model
	import pru_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       srst,
	input  wire pru_drive_s [PRU_LINES-1:0] def_pad,
	input  wire pru_drive_s [PRU_LINES-1:0] alt_pad,
	output var  logic [PRU_LINES-1:0]       def_pad_in,
	output var  logic [PRU_LINES-1:0]       alt_pad_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Undriven pads
	// ----------------------------------------
	// Pads without pull float; a pattern that moves every cycle keeps
	// a stale level from passing for a routed one
	logic [PRU_LINES-1:0] float_r;

	always_ff @(posedge clk) begin
		float_r <= srst ? 17'h0a5a5 : {float_r[PRU_LINES-2:0], ~float_r[PRU_LINES-1]};
	end

	// ----------------------------------------
	// Pad levels seen back at the inputs
	// ----------------------------------------
	always_comb begin
		for (int i = 0; i < PRU_LINES; i++) begin
			def_pad_in[i] = def_pad[i].oe ? def_pad[i].o : float_r[i];
			alt_pad_in[i] = alt_pad[i].oe ? alt_pad[i].o : ~float_r[i];
		end
	end
endmodule
`default_nettype wire

// file: testbench/pru_pin_route_unit_tb.sv
`default_nettype none
module pru_pin_route_unit_tb
	import pru_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin failures++; \
	$display("mismatch %s expected %h seen %h", nm, ex, got); end end

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam logic [7:0] MSK [4] = '{8'h37, 8'h05, 8'h3f, 8'h01};
	logic                       clk = 1'b0;
	logic                       srst = 1'b1;
	logic [PRU_ADDR_W-1:0]      aw_addr = '0;
	logic [PRU_ADDR_W-1:0]      ar_addr = '0;
	logic [31:0]                w_data = '0;
	logic [3:0]                 w_strb = '0;
	logic                       aw_valid = 1'b0;
	logic                       w_valid = 1'b0;
	logic                       b_ready = 1'b0;
	logic                       ar_valid = 1'b0;
	logic                       r_ready = 1'b0;
	logic                       split = 1'b0;
	logic [2:0]                 ev_val = '0;
	pru_drive_s [PRU_LINES-1:0] drv = '0;
	logic                       aw_ready, w_ready, b_valid, ar_ready, r_valid;
	logic [1:0]                 b_resp, r_resp;
	logic [31:0]                r_data;
	logic [PRU_LINES-1:0]       p_in, def_in, alt_in, e_in;
	pru_drive_s [PRU_LINES-1:0] def_pad, alt_pad, e_def, e_alt;
	pru_drive_s [2:0]           ev_pad, e_ev;
	logic [7:0]                 model [4] = '{default: 8'h00};
	logic [7:0]                 pend_data;
	int                         pend_idx;
	bit                         pend_ok, cmp_ok;
	logic                       bv_q = 1'b0;
	logic                       sel;
	logic [31:0]                seed = 32'h56;
	int                         failures = 0;
	int                         n_compared = 0;
	int                         cycles = 0;

	always #10 clk = ~clk;

	pru_pin_route_unit uut (.clk(clk), .srst(srst),
		.s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
		.s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
		.s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
		.s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
		.s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_valid), .s_axi_rready(r_ready), .main_pwm_timer_split(split),
		.periph_drive(drv), .periph_in(p_in), .def_pad(def_pad), .alt_pad(alt_pad),
		.def_pad_in(def_in), .alt_pad_in(alt_in), .event_value(ev_val), .event_pad(ev_pad));

	pru_pad_model u_pads (.clk(clk), .srst(srst), .def_pad(def_pad), .alt_pad(alt_pad),
		.def_pad_in(def_in), .alt_pad_in(alt_in));

	// ----------------------------------------
	// Stimulus helpers
	// ----------------------------------------
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task final_report();
		if (failures == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		bit ad, wd, bd;
		int n;
		ad = 0;
		wd = 0;
		bd = 0;
		n = 0;
		@(posedge clk);
		pend_idx = int'(a[5:2]);
		pend_data = d[7:0];
		pend_ok = s[0] && a[5:2] < 4;
		aw_addr <= a;
		w_data <= d;
		w_strb <= s;
		aw_valid <= 1'b1;
		w_valid <= 1'b1;
		b_ready <= 1'b1;
		while (!bd && n < 100) begin
			@(posedge clk);
			n++;
			if (!ad && aw_ready) begin
				ad = 1;
				aw_valid <= 1'b0;
			end
			if (!wd && w_ready) begin
				wd = 1;
				w_valid <= 1'b0;
			end
			if (b_valid) begin
				bd = 1;
				b_ready <= 1'b0;
				`CHK("bresp", er, b_resp)
			end
		end
		if (!bd) failures++;
	endtask

	task automatic axr(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit ad, rd;
		int n;
		ad = 0;
		rd = 0;
		n = 0;
		@(posedge clk);
		ar_addr <= a;
		ar_valid <= 1'b1;
		r_ready <= 1'b1;
		while (!rd && n < 100) begin
			@(posedge clk);
			n++;
			if (!ad && ar_ready) begin
				ad = 1;
				ar_valid <= 1'b0;
			end
			if (r_valid) begin
				rd = 1;
				r_ready <= 1'b0;
				`CHK("rdata", ed, r_data)
				`CHK("rresp", er, r_resp)
			end
		end
		if (!rd) failures++;
	endtask

	// ----------------------------------------
	// Free-running peripheral side and timeout
	// ----------------------------------------
	always @(posedge clk) begin
		drv <= 34'({rnd(), rnd()});
		ev_val <= 3'(rnd());
		split <= 1'(rnd());
		cycles++;
		if (cycles == 8000) begin
			failures++;
			final_report();
		end
	end

	// ----------------------------------------
	// Reference model, one clock behind its inputs
	// ----------------------------------------
	always @(negedge clk) begin
		if (b_valid && !bv_q && pend_ok) model[pend_idx] = pend_data & MSK[pend_idx];
		bv_q = b_valid;
		if (srst) model = '{default: 8'h00};
		if (cmp_ok && !srst) begin
			`CHK("def_pad", e_def, def_pad)
			`CHK("alt_pad", e_alt, alt_pad)
			`CHK("periph_in", e_in, p_in)
			`CHK("event_pad", e_ev, ev_pad)
		end
		cmp_ok = !srst;
		for (int i = 0; i < PRU_LINES; i++) begin
			sel = (i == 0) ? model[0][4] : (i == 1) ? model[0][5]
				: (i < 6) ? model[1][2] : (i < 10) ? model[1][0]
				: (i < 13) ? model[2][i-10] : (i < 16) ? (model[2][i-10] & split)
				: model[3][0];
			e_def[i] = sel ? '0 : drv[i];
			e_alt[i] = sel ? drv[i] : '0;
			e_in[i] = sel ? alt_in[i] : def_in[i];
		end
		for (int e = 0; e < 3; e++) begin
			e_ev[e].oe = model[0][e];
			e_ev[e].o = model[0][e] & ev_val[e];
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int k;
		logic [31:0] r;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++) axr(6'(i * 4), 32'h0, PRU_RESP_OKAY);
		// Every bit set, then a write with its low strobe off must leave it alone
		for (int i = 0; i < 4; i++) begin
			axw(6'(i * 4), 32'hffffffff, 4'hf, PRU_RESP_OKAY);
			axr(6'(i * 4), {24'h0, MSK[i]}, PRU_RESP_OKAY);
			axw(6'(i * 4), 32'h0, 4'he, PRU_RESP_OKAY);
			axr(6'(i * 4), {24'h0, MSK[i]}, PRU_RESP_OKAY);
		end
		axw(6'h10, 32'hff, 4'hf, PRU_RESP_SLVERR);
		axr(6'h10, 32'h0, PRU_RESP_SLVERR);
		axw(6'h3c, 32'hff, 4'hf, PRU_RESP_SLVERR);
		axr(6'h3c, 32'h0, PRU_RESP_SLVERR);
		repeat (80) begin
			k = int'(rnd() % 4);
			r = rnd();
			axw(6'(k * 4), r, r[11:8], PRU_RESP_OKAY);
			repeat (int'(rnd() % 6)) @(posedge clk);
			axr(6'(k * 4), {24'h0, model[k]}, PRU_RESP_OKAY);
		end
		@(posedge clk);
		srst <= 1'b1;
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (int i = 0; i < 4; i++) axr(6'(i * 4), 32'h0, PRU_RESP_OKAY);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire
